// file: cags_core.v
// Effective-address generation and processing-state sequencing of the CPU.
//
// How it works
// - Post-increment: address low 24, then add size.
// - Pre-decrement: subtract size first, address is result.
// - Eight-bit absolute fills upper bits with ones.
// - Sixteen-bit absolute sign-extends; 24-bit passes unchanged.
// - Decode bit number and trap vector fields.
// - PC relative: sign-extend displacement, add next PC.
// - Memory indirect: zero page pointer, low 24 target.
// - Word, longword and branch effective addresses forced even.
// - One-megabyte modes drop top four address bits.
// - Reset beats interrupt, interrupt beats trap.
// - Interrupts sampled at instruction or sequence end, and every cycle in sleep and software standby.
// - No sampling after CCR instructions or reset handling.
// - Init release starts vector fetch, interrupts blocked.
// - Init low aborts, enters reset, sets mask.
// - Entry pushes PC and CCR, masks, then vectors.
// - Mask bit always; user mask too when disabled.
// - Trap accepted in execution regardless of mask.
// - Bus request during execution releases bus, interrupts not accepted.
// - Watchdog overflow enters reset like external init.
// - Sleep with standby select clear stops CPU only.
// - Sleep with select set halts clocks, resets peripherals.
// - Hardware standby halts everything, resets peripherals.
// - Standby select is control bit 7, reset zero.
`timescale 1ns/1ps
`default_nettype none
`include "cags_defs.vh"
module cags_core (
    input  wire        i_clock,
    input  wire        i_srst,
    input  wire        i_clk_en,
    input  wire        i_hard_init_n,
    input  wire        i_hw_standby_n,
    input  wire        i_mode_1mb,
    input  wire        i_wdt_ovf,
    input  wire        i_bus_req,
    input  wire        i_irq,
    input  wire        i_irq_nmi,
    input  wire [7:0]  i_irq_vec,
    input  wire        i_instr_end,
    input  wire        i_instr_ccr,
    input  wire        i_trap,
    input  wire        i_sleep,
    input  wire [15:0] i_instr,
    input  wire [23:0] i_pc,
    input  wire        i_ea_req,
    input  wire [3:0]  i_ea_mode,
    input  wire [1:0]  i_ea_size,
    input  wire [2:0]  i_ea_reg,
    input  wire [31:0] i_ea_ext,
    input  wire        i_ar_wr,
    input  wire [2:0]  i_ar_sel,
    input  wire [31:0] i_ar_data,
    input  wire [7:0]  i_reg_addr,
    input  wire [31:0] i_reg_wdata,
    input  wire        i_reg_wr,
    input  wire        i_reg_rd,
    output reg  [31:0] o_reg_rdata,
    output reg  [23:0] o_ea,
    output reg         o_ea_valid,
    output reg  [2:0]  o_bit_num,
    output reg  [1:0]  o_trap_vec,
    output reg  [7:0]  o_state,
    output reg  [7:0]  o_ccr,
    output reg         o_cpu_halt,
    output reg         o_clock_halt,
    output reg         o_periph_reset,
    output reg         o_bus_grant,
    output reg         o_push,
    output reg  [23:0] o_push_addr,
    output reg  [31:0] o_push_data,
    output reg         o_vec_fetch,
    output reg  [7:0]  o_vec_num,
    output reg         o_branch
);
    localparam [7:0] ST_RESET   = 8'h01;
    localparam [7:0] ST_RST_EXC = 8'h02;
    localparam [7:0] ST_EXEC    = 8'h04;
    localparam [7:0] ST_EXC     = 8'h08;
    localparam [7:0] ST_BUSREL  = 8'h10;
    localparam [7:0] ST_SLEEP   = 8'h20;
    localparam [7:0] ST_SWSTBY  = 8'h40;
    localparam [7:0] ST_HWSTBY  = 8'h80;

    localparam [4:0] XS_READ_SP = 5'h01;
    localparam [4:0] XS_PUSH    = 5'h02;
    localparam [4:0] XS_MASK    = 5'h04;
    localparam [4:0] XS_VECTOR  = 5'h08;
    localparam [4:0] XS_BRANCH  = 5'h10;

    reg  [1:0]  init_sync, hw_standby_n_sync, mode_sync, ea_size;
    reg  [7:0]  system_control_reg, exc_vec, next_state, next_exc_vec;
    reg  [4:0]  exc_step;
    reg  [23:0] exc_pc, ea_raw;
    reg         irq_block, ea_busy, ea_wb, ea_even, rf_we;
    reg  [3:0]  ea_mode;
    reg  [2:0]  ea_reg, rf_raddr, rf_waddr;
    reg  [31:0] ea_ext, ea_wb_val, ea_inc, rf_wdata;
    wire [31:0] rf_rdata;
    wire        init_n   = init_sync[1];
    wire        hw_standby_n_n   = hw_standby_n_sync[1];
    wire        mode_1mb = mode_sync[1];
    wire [31:0] sp_new   = rf_rdata - `CAGS_INC_LONG;

    // Only the mask bit gates ordinary requests; the non-maskable one passes.
    wire irq_ok = i_irq_nmi | (i_irq & ~o_ccr[`CAGS_CCR_I]);
    wire irq_take = irq_ok & ~i_instr_ccr & ~irq_block;
    wire start_exc = (next_state == ST_EXC) &&
                     ((o_state != ST_EXC) || (exc_step == XS_BRANCH));
    wire [23:0] ea_even_val = ea_even ? (ea_raw & `CAGS_MASK_EVEN)
                                      : ea_raw;
    wire [23:0] ea_final = mode_1mb ? (ea_even_val & `CAGS_MASK_1MB)
                                    : ea_even_val;
    wire [23:0] push_addr = mode_1mb ? (sp_new[23:0] & `CAGS_MASK_1MB)
                                     : sp_new[23:0];

    cags_regfile u_regfile (
        .i_clock  (i_clock),
        .i_clk_en (i_clk_en),
        .i_raddr  (rf_raddr),
        .o_rdata  (rf_rdata),
        .i_we     (rf_we),
        .i_waddr  (rf_waddr),
        .i_wdata  (rf_wdata)
    );

    always @* begin
        case (ea_size)
            `CAGS_SIZE_WORD: ea_inc = `CAGS_INC_WORD;
            `CAGS_SIZE_LONG: ea_inc = `CAGS_INC_LONG;
            default:         ea_inc = `CAGS_INC_BYTE;
        endcase
    end

    always @* begin
        ea_raw    = ea_ext[23:0];
        ea_wb_val = rf_rdata;
        ea_wb     = 1'b0;
        ea_even   = (ea_size != `CAGS_SIZE_BYTE);
        case (ea_mode)
            `CAGS_MODE_POSTINC: begin
                ea_raw    = rf_rdata[23:0];
                ea_wb_val = rf_rdata + ea_inc;
                ea_wb     = 1'b1;
            end
            `CAGS_MODE_PREDEC: begin
                ea_wb_val = rf_rdata - ea_inc;
                ea_raw    = ea_wb_val[23:0];
                ea_wb     = 1'b1;
            end
            `CAGS_MODE_ABS8: begin
                ea_raw = {`CAGS_ABS8_FILL, ea_ext[7:0]};
            end
            `CAGS_MODE_ABS16: begin
                ea_raw = {{8{ea_ext[15]}}, ea_ext[15:0]};
            end
            `CAGS_MODE_ABS24: ea_raw = ea_ext[23:0];
            `CAGS_MODE_PCREL8: begin
                ea_raw  = i_pc + {{16{ea_ext[7]}}, ea_ext[7:0]};
                ea_even = 1'b1;
            end
            `CAGS_MODE_PCREL16: begin
                ea_raw  = i_pc + {{8{ea_ext[15]}}, ea_ext[15:0]};
                ea_even = 1'b1;
            end
            `CAGS_MODE_MIND_PTR: begin
                ea_raw  = {`CAGS_MIND_FILL, ea_ext[7:0]};
                ea_even = 1'b1;
            end
            `CAGS_MODE_MIND_TGT: begin
                // The top byte of the fetched longword is dropped.
                ea_raw  = ea_ext[23:0];
                ea_even = 1'b1;
            end
            default: ea_raw = ea_ext[23:0];
        endcase
    end

    always @* begin
        rf_raddr = i_ea_reg;
        if ((o_state == ST_EXC) && (exc_step == XS_READ_SP)) begin
            rf_raddr = `CAGS_SP_SEL;
        end
        // Internal write-back wins; an outside load in that cycle is lost.
        if (ea_busy && ea_wb) begin
            rf_we    = 1'b1;
            rf_waddr = ea_reg;
            rf_wdata = ea_wb_val;
        end else if ((o_state == ST_EXC) && (exc_step == XS_PUSH)) begin
            rf_we    = 1'b1;
            rf_waddr = `CAGS_SP_SEL;
            rf_wdata = sp_new;
        end else begin
            rf_we    = i_ar_wr;
            rf_waddr = i_ar_sel;
            rf_wdata = i_ar_data;
        end
    end

    always @* begin
        next_state   = o_state;
        next_exc_vec = exc_vec;
        if (!hw_standby_n_n) begin
            next_state = ST_HWSTBY;
        end else if (!init_n || i_wdt_ovf) begin
            next_state = ST_RESET;
        end else begin
            case (o_state)
                ST_RESET:   next_state = ST_RST_EXC;
                ST_RST_EXC: next_state = ST_EXEC;
                ST_EXEC: begin
                    if (i_instr_end && irq_take) begin
                        next_state   = ST_EXC;
                        next_exc_vec = i_irq_vec;
                    end else if (i_instr_end && i_trap) begin
                        next_state   = ST_EXC;
                        next_exc_vec = {`CAGS_VEC_TRAP_BASE, o_trap_vec};
                    end else if (i_instr_end && i_sleep) begin
                        if (system_control_reg[`CAGS_SYSTEM_CONTROL_REG_SOFT_STANDBY_SEL]) begin
                            next_state = ST_SWSTBY;
                        end else begin
                            next_state = ST_SLEEP;
                        end
                    end else if (i_bus_req && !ea_busy) begin
                        next_state = ST_BUSREL;
                    end
                end
                ST_EXC: begin
                    if (exc_step == XS_BRANCH) begin
                        if (irq_ok) begin
                            next_exc_vec = i_irq_vec;
                        end else begin
                            next_state = ST_EXEC;
                        end
                    end
                end
                ST_BUSREL: begin
                    // Interrupts wait until the bus comes back.
                    if (!i_bus_req) next_state = ST_EXEC;
                end
                ST_SLEEP, ST_SWSTBY: begin
                    if (irq_ok) begin
                        next_state   = ST_EXC;
                        next_exc_vec = i_irq_vec;
                    end
                end
                ST_HWSTBY: next_state = ST_RESET;
                default:   next_state = ST_RESET;
            endcase
        end
    end

    always @(posedge i_clock) begin
        if (i_srst) begin
            init_sync      <= 2'h0;
            hw_standby_n_sync      <= 2'h3;
            mode_sync      <= 2'h0;
            o_state        <= ST_RESET;
            system_control_reg          <= `CAGS_SYSTEM_CONTROL_REG_RESET;
            o_ccr          <= `CAGS_CCR_RESET;
            exc_step       <= XS_READ_SP;
            irq_block      <= 1'b1;
            ea_busy        <= 1'b0;
            o_reg_rdata    <= `CAGS_ZERO32;
            o_ea           <= `CAGS_ZERO24;
            o_ea_valid     <= 1'b0;
            o_bit_num      <= 3'h0;
            o_trap_vec     <= 2'h0;
            o_cpu_halt     <= 1'b1;
            o_clock_halt   <= 1'b0;
            o_periph_reset <= 1'b0;
            o_bus_grant    <= 1'b0;
            o_push         <= 1'b0;
            o_push_addr    <= `CAGS_ZERO24;
            o_push_data    <= `CAGS_ZERO32;
            o_vec_fetch    <= 1'b0;
            o_vec_num      <= `CAGS_ZERO8;
            o_branch       <= 1'b0;
        end else if (i_clk_en) begin
            init_sync <= {init_sync[0], i_hard_init_n};
            hw_standby_n_sync <= {hw_standby_n_sync[0], i_hw_standby_n};
            mode_sync <= {mode_sync[0], i_mode_1mb};

            o_state        <= next_state;
            exc_vec        <= next_exc_vec;
            o_cpu_halt     <= (next_state != ST_EXEC) &&
                              (next_state != ST_EXC) &&
                              (next_state != ST_RST_EXC);
            o_clock_halt   <= (next_state == ST_SWSTBY) ||
                              (next_state == ST_HWSTBY);
            o_periph_reset <= (next_state == ST_SWSTBY) ||
                              (next_state == ST_HWSTBY);
            o_bus_grant    <= (next_state == ST_BUSREL);
            o_push         <= 1'b0;
            o_vec_fetch    <= 1'b0;
            o_branch       <= 1'b0;
            o_ea_valid     <= 1'b0;

            // Decode fields are registered every cycle from the opcode.
            o_bit_num  <= i_instr[`CAGS_BITNUM_HI:`CAGS_BITNUM_LO];
            o_trap_vec <= i_instr[`CAGS_TRAPV_HI:`CAGS_TRAPV_LO];

            if (start_exc) begin
                exc_step <= XS_READ_SP;
                exc_pc   <= i_pc;
            end else if (o_state == ST_EXC) begin
                case (exc_step)
                    XS_READ_SP: exc_step <= XS_PUSH;
                    XS_PUSH: begin
                        o_push      <= 1'b1;
                        o_push_addr <= push_addr;
                        o_push_data <= {o_ccr, exc_pc};
                        exc_step    <= XS_MASK;
                    end
                    XS_MASK: exc_step <= XS_VECTOR;
                    XS_VECTOR: begin
                        o_vec_fetch <= 1'b1;
                        o_vec_num   <= exc_vec;
                        exc_step    <= XS_BRANCH;
                    end
                    XS_BRANCH: o_branch <= 1'b1;
                    default:   exc_step <= XS_READ_SP;
                endcase
            end

            if (o_state == ST_RST_EXC) begin
                o_vec_fetch <= 1'b1;
                o_vec_num   <= `CAGS_VEC_RESET;
                o_branch    <= 1'b1;
            end

            // Blocked from reset until the first instruction has completed.
            if ((next_state == ST_RESET) || (o_state == ST_RST_EXC)) begin
                irq_block <= 1'b1;
            end else if ((o_state == ST_EXEC) && i_instr_end) begin
                irq_block <= 1'b0;
            end

            if (next_state == ST_RESET) begin
                o_ccr[`CAGS_CCR_I] <= 1'b1;
            end else if ((o_state == ST_EXC) && (exc_step == XS_MASK)) begin
                o_ccr[`CAGS_CCR_I] <= 1'b1;
                if (!system_control_reg[`CAGS_SYSTEM_CONTROL_REG_UE]) o_ccr[`CAGS_CCR_UI] <= 1'b1;
            end else if (i_reg_wr && (i_reg_addr == `CAGS_OFF_CCR)) begin
                o_ccr <= i_reg_wdata[7:0];
            end

            if (i_reg_wr && (i_reg_addr == `CAGS_OFF_SYSTEM_CONTROL_REG)) begin
                system_control_reg <= i_reg_wdata[7:0];
            end

            if (i_reg_rd) begin
                case (i_reg_addr)
                    `CAGS_OFF_SYSTEM_CONTROL_REG:   o_reg_rdata <= {24'h00_0000, system_control_reg};
                    `CAGS_OFF_CCR:     o_reg_rdata <= {24'h00_0000, o_ccr};
                    `CAGS_OFF_STATE:   o_reg_rdata <= {24'h00_0000, o_state};
                    `CAGS_OFF_LAST_EA: o_reg_rdata <= {8'h00, o_ea};
                    default:           o_reg_rdata <= `CAGS_ZERO32;
                endcase
            end

            // Requests arriving outside execution or mid-calculation drop.
            if (ea_busy) begin
                ea_busy    <= 1'b0;
                o_ea       <= ea_final;
                o_ea_valid <= 1'b1;
            end else if (i_ea_req && (o_state == ST_EXEC) &&
                         (next_state == ST_EXEC)) begin
                ea_busy <= 1'b1;
                ea_mode <= i_ea_mode;
                ea_size <= i_ea_size;
                ea_reg  <= i_ea_reg;
                ea_ext  <= i_ea_ext;
            end
        end
    end
endmodule
`default_nettype wire

// file: cags_defs.vh
// Shared constants for the address generator and processing-state control.
`ifndef CAGS_DEFS_VH
`define CAGS_DEFS_VH

`define CAGS_MODE_POSTINC   4'h0
`define CAGS_MODE_PREDEC    4'h1
`define CAGS_MODE_ABS8      4'h2
`define CAGS_MODE_ABS16     4'h3
`define CAGS_MODE_ABS24     4'h4
`define CAGS_MODE_PCREL8    4'h5
`define CAGS_MODE_PCREL16   4'h6
`define CAGS_MODE_MIND_PTR  4'h7
`define CAGS_MODE_MIND_TGT  4'h8

`define CAGS_SIZE_BYTE      2'h0
`define CAGS_SIZE_WORD      2'h1
`define CAGS_SIZE_LONG      2'h2

`define CAGS_INC_BYTE       32'h0000_0001
`define CAGS_INC_WORD       32'h0000_0002
`define CAGS_INC_LONG       32'h0000_0004

`define CAGS_ABS8_FILL      16'hFFFF
`define CAGS_MIND_FILL      16'h0000
`define CAGS_MASK_1MB       24'h0F_FFFF
`define CAGS_MASK_EVEN      24'hFF_FFFE

`define CAGS_OFF_SYSTEM_CONTROL_REG      8'h00
`define CAGS_OFF_CCR        8'h04
`define CAGS_OFF_STATE      8'h08
`define CAGS_OFF_LAST_EA    8'h0C

`define CAGS_SYSTEM_CONTROL_REG_RESET    8'h0B
`define CAGS_SYSTEM_CONTROL_REG_SOFT_STANDBY_SEL     7
`define CAGS_SYSTEM_CONTROL_REG_UE       3
`define CAGS_CCR_RESET      8'h80
`define CAGS_CCR_I          7
`define CAGS_CCR_UI         6

`define CAGS_BITNUM_HI      6
`define CAGS_BITNUM_LO      4
`define CAGS_TRAPV_HI       5
`define CAGS_TRAPV_LO       4

`define CAGS_SP_SEL         3'h7
`define CAGS_VEC_RESET      8'h00
`define CAGS_VEC_TRAP_BASE  6'h02
`define CAGS_ZERO32         32'h0000_0000
`define CAGS_ZERO24         24'h00_0000
`define CAGS_ZERO8          8'h00

`endif

// file: cags_regfile.v
// Eight 32-bit address registers with one write port and a registered read.
`timescale 1ns/1ps
`default_nettype none
module cags_regfile (
    input  wire        i_clock,
    input  wire        i_clk_en,
    input  wire [2:0]  i_raddr,
    output reg  [31:0] o_rdata,
    input  wire        i_we,
    input  wire [2:0]  i_waddr,
    input  wire [31:0] i_wdata
);
    reg [31:0] mem [0:7];

    // A read in the cycle of a write to the same entry returns the old value.
    always @(posedge i_clock) begin
        if (i_clk_en) begin
            if (i_we) begin
                mem[i_waddr] <= i_wdata;
            end
            o_rdata <= mem[i_raddr];
        end
    end
endmodule
`default_nettype wire

// file: cags_chk.sv
// Port-level checks on the address generator and state control.
`timescale 1ns/1ps
`default_nettype none
module cags_chk (
    input wire logic        i_clock,
    input wire logic        i_srst,
    input wire logic        i_hard_init_n,
    input wire logic        i_hw_standby_n,
    input wire logic        i_mode_1mb,
    input wire logic        i_wdt_ovf,
    input wire logic [15:0] i_instr,
    input wire logic        i_ea_req,
    input wire logic [3:0]  i_ea_mode,
    input wire logic [1:0]  i_ea_size,
    input wire logic [23:0] o_ea,
    input wire logic        o_ea_valid,
    input wire logic [2:0]  o_bit_num,
    input wire logic [1:0]  o_trap_vec,
    input wire logic [7:0]  o_state,
    input wire logic [7:0]  o_ccr,
    input wire logic        o_cpu_halt,
    input wire logic        o_clock_halt,
    input wire logic        o_periph_reset,
    input wire logic        o_bus_grant,
    input wire logic        o_push,
    input wire logic        o_vec_fetch,
    input wire logic        o_branch
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_srst);
    a_ea_answer: assert property (o_ea_valid |->
        $past(i_ea_req, 2)) else $error("result without request");
    a_abs8_fill: assert property (o_ea_valid &&
        $past(i_ea_mode, 2) == 4'h2 |-> o_ea[15:8] == 8'hFF)
        else $error("short absolute not filled");
    a_mind_zero: assert property (o_ea_valid &&
        $past(i_ea_mode, 2) == 4'h7 |-> o_ea[23:8] == 16'h0000)
        else $error("pointer not in page 0");
    a_even_addr: assert property (o_ea_valid &&
        ($past(i_ea_size, 2) != 2'h0 || $past(i_ea_mode, 2) > 4'h4)
        |-> !o_ea[0]) else $error("odd address");
    a_trunc_1mb: assert property (o_ea_valid &&
        $past(i_mode_1mb, 3) && $past(i_mode_1mb, 5)
        |-> o_ea[23:20] == 4'h0) else $error("no 20-bit cut");
    a_init_reset: assert property (
        (!i_hard_init_n && i_hw_standby_n)[*3] |=> o_state == 8'h01
        && o_ccr[7] && o_cpu_halt) else $error("init low ignored");
    a_wdt_reset: assert property (i_wdt_ovf && i_hw_standby_n
        |-> ##[1:2] o_state == 8'h01) else $error("watchdog ignored");
    a_hw_standby: assert property (!i_hw_standby_n[*3]
        |=> o_state == 8'h80 && o_clock_halt && o_periph_reset)
        else $error("standby pin ignored");
    a_sleep_only: assert property (o_state == 8'h20 |->
        o_cpu_halt && !o_clock_halt && !o_periph_reset)
        else $error("sleep stops too much");
    a_soft_hw_standby_n: assert property (o_state == 8'h40 |->
        o_cpu_halt && o_clock_halt && o_periph_reset)
        else $error("soft standby incomplete");
    a_bus_release: assert property (o_bus_grant |->
        o_state == 8'h10 && o_cpu_halt && !o_push && !o_vec_fetch)
        else $error("busy while bus released");
    a_entry_order: assert property (o_push |=>
        o_ccr[7] ##1 o_vec_fetch ##1 o_branch)
        else $error("entry steps out of order");
    a_bit_fields: assert property (!$past(i_srst) |->
        o_bit_num == $past(i_instr[6:4]) && o_trap_vec == $past(i_instr[5:4]))
        else $error("immediate field wrong");
    c_push: cover property (o_push);
    c_grant: cover property (o_bus_grant);
    c_soft_hw_standby_n: cover property (o_state == 8'h40);
    c_ea_1mb: cover property (o_ea_valid && i_mode_1mb);
endmodule
bind cags_core cags_chk i_chk (.*);
`default_nettype wire

// file: cags_bus_model.sv
// Other bus master that borrows the shared memory bus for a few cycles.
`timescale 1ns/1ps
`default_nettype none
module cags_bus_model (
    input  wire logic       i_clock,
    input  wire logic       i_srst,
    input  wire logic       i_start,
    input  wire logic [3:0] i_hold,
    input  wire logic       i_bus_grant,
    output var  logic       o_bus_req
);
    logic [3:0] count;
    // The request holds until its last granted cycle has ended.
    always @(posedge i_clock) begin
        if (i_srst) begin
            o_bus_req <= 1'b0;
            count     <= 4'h0;
        end else if (i_start && !o_bus_req) begin
            o_bus_req <= 1'b1;
            count     <= i_hold;
        end else if (o_bus_req && i_bus_grant) begin
            if (count == 4'h0) o_bus_req <= 1'b0;
            count <= count - 4'h1;
        end
    end
endmodule
`default_nettype wire

// file: tb.sv
// Self-checking bench for the address generator and state control.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        i_clock = 0, i_srst = 1, i_clk_en = 1, bus_start = 0;
    logic        i_hard_init_n = 1, i_hw_standby_n = 1, i_mode_1mb = 0;
    logic        i_wdt_ovf = 0, i_irq = 0, i_irq_nmi = 0, i_instr_end = 0;
    logic        i_instr_ccr = 0, i_trap = 0, i_sleep = 0, i_ea_req = 0;
    logic        i_ar_wr = 0, i_reg_wr = 0, i_reg_rd = 0, i_bus_req, ue;
    logic [7:0]  i_irq_vec = '0, i_reg_addr = '0, o_state, o_ccr, o_vec_num;
    logic [7:0]  ccr = 8'h80;
    logic [15:0] i_instr = '0;
    logic [23:0] i_pc = '0, o_ea, o_push_addr;
    logic [3:0]  i_ea_mode = '0, hold = '0;
    logic [1:0]  i_ea_size = '0, o_trap_vec;
    logic [2:0]  i_ea_reg = '0, i_ar_sel = '0, o_bit_num;
    logic [31:0] i_ea_ext = '0, i_ar_data = '0, i_reg_wdata = '0;
    logic [31:0] o_reg_rdata, o_push_data, ar [8];
    logic        o_ea_valid, o_cpu_halt, o_clock_halt, o_periph_reset;
    logic        o_bus_grant, o_push, o_vec_fetch, o_branch;
    int          failures = 0, checks = 0;
    wire logic [3:0] flags = {o_bus_grant, o_ea_valid, o_vec_fetch, o_push};
    cags_core i_dut (.*);
    cags_bus_model i_bus (.i_clock, .i_srst, .i_start(bus_start),
        .i_hold(hold), .i_bus_grant(o_bus_grant), .o_bus_req(i_bus_req));
    always #2 i_clock = ~i_clock;
    task automatic stop_test();
        if (failures == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(string n, logic [31:0] s, logic [31:0] e);
        checks++;
        if (s !== e) begin
            failures++;
            $display("CHECK FAILED %s exp %h seen %h", n, e, s);
        end
    endtask
    // Index 4 waits for a state code, lower ones for a flag.
    task automatic wait_on(int k, logic [7:0] s);
        int n = 0;
        do begin
            @(posedge i_clock);
            #1 n++;
        end while (!(k < 4 ? flags[k] === 1'b1 : o_state === s) && n < 60);
        if (n >= 60) begin
            failures++;
            stop_test();
        end
    endtask
    task automatic reg_wr(logic [7:0] a, logic [31:0] d);
        @(posedge i_clock);
        i_reg_wr <= 1;
        i_reg_addr <= a;
        i_reg_wdata <= d;
        @(posedge i_clock);
        i_reg_wr <= 0;
    endtask
    task automatic reg_rd(logic [7:0] a, logic [31:0] e, string n);
        @(posedge i_clock);
        i_reg_rd <= 1;
        i_reg_addr <= a;
        @(posedge i_clock);
        i_reg_rd <= 0;
        #1 check(n, o_reg_rdata, e);
    endtask
    task automatic endi(logic c, logic t, logic s);
        @(posedge i_clock);
        {i_instr_end, i_instr_ccr, i_trap, i_sleep} <= {1'b1, c, t, s};
        i_pc <= 24'($urandom);
        @(posedge i_clock);
        {i_instr_end, i_instr_ccr, i_trap, i_sleep} <= 4'h0;
    endtask
    task automatic exc(logic go, logic t, logic [7:0] v);
        if (go) endi(0, t, 0);
        wait_on(0, 0);
        {i_irq, i_irq_nmi} <= 2'h0;
        ar[7] -= 4;
        check("push_addr", o_push_addr, ar[7][23:0]);
        check("push_data", o_push_data, {ccr, i_pc});
        ccr[7] = 1;
        ccr[6] = ccr[6] | !ue;
        wait_on(1, 0);
        check("vec_num", o_vec_num, v);
        wait_on(4, 8'h04);
        check("ccr", o_ccr, ccr);
    endtask
    function automatic logic [23:0] ea_exp(logic [3:0] m, logic [1:0] s,
                                           logic [31:0] x, logic [31:0] r);
        logic [23:0] a;
        case (m)
            0: a = r[23:0];
            1: a = 24'(r - (32'h1 << s));
            2: a = {16'hFFFF, x[7:0]};
            3: a = {{8{x[15]}}, x[15:0]};
            5: a = i_pc + {{16{x[7]}}, x[7:0]};
            6: a = i_pc + {{8{x[15]}}, x[15:0]};
            7: a = {16'h0000, x[7:0]};
            default: a = x[23:0];
        endcase
        if (s != 0 || m > 4) a[0] = 0;
        if (i_mode_1mb) a[23:20] = 4'h0;
        return a;
    endfunction
    task automatic ea(logic [3:0] m, logic [1:0] s, logic [2:0] r, logic [31:0] x);
        logic [23:0] e;
        @(posedge i_clock);
        {i_ea_req, i_ea_mode, i_ea_size, i_ea_reg, i_ea_ext} <= {1'b1, m, s, r, x};
        i_instr <= 16'($urandom);
        i_pc <= 24'($urandom);
        @(posedge i_clock);
        i_ea_req <= 0;
        e = ea_exp(m, s, x, ar[r]);
        if (m < 2) ar[r] = m ? ar[r] - (32'h1 << s) : ar[r] + (32'h1 << s);
        wait_on(2, 0);
        check("ea", o_ea, e);
        check("bit_num", o_bit_num, i_instr[6:4]);
    endtask
    initial begin
        ar[0] = $urandom(32'h4f93_fa76);
        repeat (4) @(posedge i_clock);
        i_srst <= 0;
        wait_on(4, 8'h04);
        reg_rd(8'h00, 32'h0000_000B, "sysctl");
        reg_rd(8'h04, 32'h0000_0080, "ccr");
        reg_rd(8'h10, 32'h0000_0000, "unmapped");
        for (int i = 0; i < 8; i++) begin
            ar[i] = $urandom;
            @(posedge i_clock);
            {i_ar_wr, i_ar_sel, i_ar_data} <= {1'b1, 3'(i), ar[i]};
        end
        @(posedge i_clock);
        i_ar_wr <= 0;
        i_irq_nmi <= 1;
        endi(0, 0, 0);
        repeat (3) @(posedge i_clock);
        #1 check("state", o_state, 8'h04);
        endi(1, 0, 0);
        repeat (3) @(posedge i_clock);
        #1 check("state", o_state, 8'h04);
        i_irq_nmi <= 0;
        reg_wr(8'h04, 0);
        {ccr, ue} = 9'h001;
        i_irq_vec <= 8'($urandom);
        i_irq <= 1;
        repeat (3) @(posedge i_clock);
        #1 check("state", o_state, 8'h04);
        exc(1, 0, i_irq_vec);
        reg_wr(8'h00, 0);
        ue = 0;
        for (int v = 0; v < 4; v++) begin
            i_instr <= 16'(v << 4);
            exc(1, 1, {6'h02, 2'(v)});
        end
        i_irq <= 1;
        exc(1, 1, 8'h0B);
        i_irq_nmi <= 1;
        exc(1, 1, i_irq_vec);
        hold <= 4'($urandom);
        bus_start <= 1;
        endi(0, 0, 0);
        bus_start <= 0;
        wait_on(3, 0);
        check("halt", o_cpu_halt, 1);
        wait_on(4, 8'h04);
        reg_wr(8'h00, 32'h0000_0008);
        ue = 1;
        endi(0, 0, 1);
        wait_on(4, 8'h20);
        i_irq_nmi <= 1;
        exc(0, 0, i_irq_vec);
        reg_wr(8'h00, 32'h0000_0088);
        reg_rd(8'h00, 32'h0000_0088, "sysctl");
        endi(0, 0, 1);
        wait_on(4, 8'h40);
        i_irq_nmi <= 1;
        exc(0, 0, i_irq_vec);
        i_hw_standby_n <= 0;
        wait_on(4, 8'h80);
        i_hw_standby_n <= 1;
        wait_on(4, 8'h04);
        i_wdt_ovf <= 1;
        @(posedge i_clock);
        i_wdt_ovf <= 0;
        wait_on(1, 0);
        check("vec_num", o_vec_num, 0);
        wait_on(4, 8'h04);
        reg_wr(8'h04, 0);
        i_hard_init_n <= 0;
        wait_on(4, 8'h01);
        check("ccr", o_ccr, 32'h0000_0080);
        i_hard_init_n <= 1;
        wait_on(1, 0);
        check("vec_num", o_vec_num, 0);
        wait_on(4, 8'h04);
        for (int k = 0; k < 2; k++) begin
            i_mode_1mb <= k[0];
            repeat (6) @(posedge i_clock);
            ea(3, 1, 2, 32'h0000_8001);
            ea(5, 0, 3, 32'h0000_0080);
            ea(6, 1, 3, 32'h0000_7FFF);
            repeat (40) ea(4'($urandom_range(8)), 2'($urandom_range(2)),
                           3'($urandom), $urandom);
        end
        stop_test();
    end
endmodule
`default_nettype wire
